// ---- core/nic_misc_csr_bank.sv ----
// misc csr bank: tx irq enables, lost counter, eeprom port, timer, irqs
// Overview of operation
// - desc-unavailable irq enabled only by its bit 2 plus normal summary.
// - tx-stopped irq enabled only by its bit 1 plus abnormal summary.
// - tx-done irq needs bit 0 plus normal summary; all reset low.
// - lost count increments on each frame dropped for lack of descriptor, stopping at all ones.
// - reading the lost counter clears the count; count resets to zero.
// - overflow flag at bit 16 sets on overflow, holds, read clears.
// - eeprom read access needs read control bit 14 and select bit 11.
// - eeprom write access needs write control bit 13 and select bit 11.
// - eeprom reached only while select bit 11 set; these reset low.
// - eeprom data-out shown on read-only bit 3, reset value one.
// - software writes data-in bit 2; driven to eeprom; resets one.
// - software toggles bit 1 as eeprom clock; drives pin; resets one.
// - bit 0 selects eeprom chip; drives chip select; resets one.
// - timer bit 16 chooses continuous mode; resets low.
// - normal and abnormal summary enables gate their whole groups.
// - timer expiry irq needs timer enable and abnormal summary.
`timescale 1ns/10ps
module nic_misc_csr_bank #(
  parameter int CNT_W = 16,
  parameter int TICK_CYCLES = nic_misc_csr_pkg::TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // register port
  input wire nic_misc_csr_pkg::csr_req_t req_i,
  output logic [31:0] rdata_o,
  // events from the mac
  input wire logic frame_dropped_i,
  input wire logic tx_done_i,
  input wire logic tx_stopped_i,
  input wire logic tx_desc_unavail_i,
  // serial eeprom
  input wire logic eeprom_serial_out_i,
  output nic_misc_csr_pkg::ee_pins_t eeprom_o,
  // interrupt
  output logic irq_o
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ==========================================================
  // address decode
  logic wr_ier, wr_spr, wr_tmr, wr_stat, wr_mask, rd_lpc;

  assign wr_ier = req_i.wr && (req_i.addr == nic_misc_csr_pkg::OFS_IER);
  assign wr_spr = req_i.wr && (req_i.addr == nic_misc_csr_pkg::OFS_SPR);
  assign wr_tmr = req_i.wr && (req_i.addr == nic_misc_csr_pkg::OFS_TMR);
  assign wr_stat = req_i.wr && (req_i.addr == nic_misc_csr_pkg::OFS_IRQ_STAT);
  assign wr_mask = req_i.wr && (req_i.addr == nic_misc_csr_pkg::OFS_IRQ_MASK);
  assign rd_lpc = req_i.rd && (req_i.addr == nic_misc_csr_pkg::OFS_LPC);

  // ==========================================================
  // interrupt enable register
  logic normal_summary_en_q, abnormal_summary_en_q;
  logic timer_expired_irq_en_q, tx_desc_unavail_irq_en_q;
  logic tx_stopped_irq_en_q, tx_done_irq_en_q;

  // all enables come up disabled
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      normal_summary_en_q <= 1'b0;
      abnormal_summary_en_q <= 1'b0;
      timer_expired_irq_en_q <= 1'b0;
      tx_desc_unavail_irq_en_q <= 1'b0;
      tx_stopped_irq_en_q <= 1'b0;
      tx_done_irq_en_q <= 1'b0;
    end else if (ce_i && wr_ier) begin
      normal_summary_en_q <= req_i.wdata[nic_misc_csr_pkg::IER_NORMAL];
      abnormal_summary_en_q <= req_i.wdata[nic_misc_csr_pkg::IER_ABNORMAL];
      timer_expired_irq_en_q <= req_i.wdata[nic_misc_csr_pkg::IER_TIMER];
      tx_desc_unavail_irq_en_q <= req_i.wdata[nic_misc_csr_pkg::IER_TX_DESC];
      tx_stopped_irq_en_q <= req_i.wdata[nic_misc_csr_pkg::IER_TX_STOP];
      tx_done_irq_en_q <= req_i.wdata[nic_misc_csr_pkg::IER_TX_DONE];
    end
  end

  // effective enables: summary bits act as group master gates
  logic [nic_misc_csr_pkg::N_EVT-1:0] evt_en;

  assign evt_en[nic_misc_csr_pkg::ST_TX_DONE] =
    tx_done_irq_en_q && normal_summary_en_q;
  assign evt_en[nic_misc_csr_pkg::ST_TX_STOP] =
    tx_stopped_irq_en_q && abnormal_summary_en_q;
  assign evt_en[nic_misc_csr_pkg::ST_TX_DESC] =
    tx_desc_unavail_irq_en_q && normal_summary_en_q;
  assign evt_en[nic_misc_csr_pkg::ST_TIMER] =
    timer_expired_irq_en_q && abnormal_summary_en_q;
  // overflow has no enable of its own, the mask alone gates it
  assign evt_en[nic_misc_csr_pkg::ST_LPC_OVF] = 1'b1;

  // ==========================================================
  // lost packet counter
  logic [CNT_W-1:0] dropped_frame_count_q;
  logic dropped_count_overflow_q;
  logic lpc_ovf_evt;

  // first drop past the top of the count is the overflow event
  assign lpc_ovf_evt = frame_dropped_i && !rd_lpc &&
                       (&dropped_frame_count_q) &&
                       !dropped_count_overflow_q;

  // a drop in the read cycle is counted after the clear, not lost
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dropped_frame_count_q <= '0;
      dropped_count_overflow_q <= 1'b0;
    end else if (ce_i) begin
      if (rd_lpc) begin
        dropped_frame_count_q <= frame_dropped_i ? CNT_ONE : '0;
        dropped_count_overflow_q <= 1'b0;
      end else if (frame_dropped_i) begin
        if (&dropped_frame_count_q) begin
          dropped_count_overflow_q <= 1'b1;
        end else begin
          dropped_frame_count_q <= dropped_frame_count_q + CNT_ONE;
        end
      end
    end
  end

  // ==========================================================
  // serial eeprom port
  logic eeprom_read_ctrl_q, eeprom_write_ctrl_q, eeprom_port_select_q;
  logic eeprom_serial_out_q, eeprom_serial_in_q;
  logic eeprom_clk_q, eeprom_chip_sel_q;
  logic ee_rd_grant, ee_grant;

  assign ee_rd_grant = eeprom_port_select_q && eeprom_read_ctrl_q;
  // the pins move for either direction: a read still needs opcodes
  assign ee_grant = eeprom_port_select_q &&
                    (eeprom_read_ctrl_q || eeprom_write_ctrl_q);

  // software-written port bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eeprom_read_ctrl_q <= 1'b0;
      eeprom_write_ctrl_q <= 1'b0;
      eeprom_port_select_q <= 1'b0;
      eeprom_serial_in_q <= nic_misc_csr_pkg::SPR_PIN_RST;
      eeprom_clk_q <= nic_misc_csr_pkg::SPR_PIN_RST;
      eeprom_chip_sel_q <= nic_misc_csr_pkg::SPR_PIN_RST;
    end else if (ce_i && wr_spr) begin
      eeprom_read_ctrl_q <= req_i.wdata[nic_misc_csr_pkg::SPR_RD];
      eeprom_write_ctrl_q <= req_i.wdata[nic_misc_csr_pkg::SPR_WR];
      eeprom_port_select_q <= req_i.wdata[nic_misc_csr_pkg::SPR_SEL];
      eeprom_serial_in_q <= req_i.wdata[nic_misc_csr_pkg::SPR_DI];
      eeprom_clk_q <= req_i.wdata[nic_misc_csr_pkg::SPR_CLK];
      eeprom_chip_sel_q <= req_i.wdata[nic_misc_csr_pkg::SPR_CS];
    end
  end

  // data-out sampled only while read access is granted, else held
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eeprom_serial_out_q <= nic_misc_csr_pkg::SPR_PIN_RST;
    end else if (ce_i && ee_rd_grant) begin
      eeprom_serial_out_q <= eeprom_serial_out_i;
    end
  end

  // pins low while the port is not granted, so a stray bit
  // pattern in the register cannot clock the part
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eeprom_o <= '0;
    end else if (ce_i) begin
      eeprom_o.cs <= ee_grant && eeprom_chip_sel_q;
      eeprom_o.clk <= ee_grant && eeprom_clk_q;
      eeprom_o.di <= ee_grant && eeprom_serial_in_q;
    end
  end

  // ==========================================================
  // general-purpose timer
  logic timer_continuous_q;
  logic [15:0] timer_load_value_q, timer_count_q;
  logic [TW-1:0] tick_cnt_q;
  nic_misc_csr_pkg::tmr_state_t tmr_state_q;
  logic tick_end, timer_evt;

  assign tick_end = (tick_cnt_q == TICK_LAST);
  assign timer_evt = (tmr_state_q == nic_misc_csr_pkg::TMR_RUN) &&
                     tick_end && (timer_count_q == 16'h0001) && !wr_tmr;

  // a write restarts the tick so the first step is a full period
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_continuous_q <= 1'b0;
      timer_load_value_q <= nic_misc_csr_pkg::TMR_VALUE_RST;
      timer_count_q <= nic_misc_csr_pkg::TMR_VALUE_RST;
      tick_cnt_q <= '0;
      tmr_state_q <= nic_misc_csr_pkg::TMR_IDLE;
    end else if (ce_i) begin
      if (wr_tmr) begin
        timer_continuous_q <= req_i.wdata[nic_misc_csr_pkg::TMR_CONT];
        timer_load_value_q <= req_i.wdata[15:0];
        timer_count_q <= req_i.wdata[15:0];
        tick_cnt_q <= '0;
        tmr_state_q <= (req_i.wdata[15:0] != 16'h0000) ?
                       nic_misc_csr_pkg::TMR_RUN :
                       nic_misc_csr_pkg::TMR_IDLE;
      end else begin
        case (tmr_state_q)
          nic_misc_csr_pkg::TMR_IDLE: begin
            tick_cnt_q <= '0;
          end
          nic_misc_csr_pkg::TMR_RUN: begin
            if (tick_end) begin
              tick_cnt_q <= '0;
              if (timer_count_q == 16'h0001) begin
                if (timer_continuous_q) begin
                  timer_count_q <= timer_load_value_q;
                end else begin
                  timer_count_q <= 16'h0000;
                  tmr_state_q <= nic_misc_csr_pkg::TMR_IDLE;
                end
              end else begin
                timer_count_q <= timer_count_q - 16'h0001;
              end
            end else begin
              tick_cnt_q <= tick_cnt_q + TW'(1);
            end
          end
          default: begin
            tmr_state_q <= nic_misc_csr_pkg::TMR_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // interrupt status, mask and output
  logic [nic_misc_csr_pkg::N_EVT-1:0] evt_vec, irq_status_q, irq_mask_q;

  assign evt_vec[nic_misc_csr_pkg::ST_TX_DONE] = tx_done_i;
  assign evt_vec[nic_misc_csr_pkg::ST_TX_STOP] = tx_stopped_i;
  assign evt_vec[nic_misc_csr_pkg::ST_TX_DESC] = tx_desc_unavail_i;
  assign evt_vec[nic_misc_csr_pkg::ST_TIMER] = timer_evt;
  assign evt_vec[nic_misc_csr_pkg::ST_LPC_OVF] = lpc_ovf_evt;

  // sticky bits, write one to clear; a set in the same cycle wins
  for (genvar i = 0; i < nic_misc_csr_pkg::N_EVT; i++) begin : g_stat
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        irq_status_q[i] <= 1'b0;
      end else if (ce_i) begin
        if (evt_vec[i]) begin
          irq_status_q[i] <= 1'b1;
        end else if (wr_stat && req_i.wdata[i]) begin
          irq_status_q[i] <= 1'b0;
        end
      end
    end
  end

  // mask register, same layout as status
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_mask_q <= '0;
    end else if (ce_i && wr_mask) begin
      irq_mask_q <= req_i.wdata[nic_misc_csr_pkg::N_EVT-1:0];
    end
  end

  // registered level, one cycle behind the status bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_status_q & irq_mask_q & evt_en);
    end
  end

  // ==========================================================
  // read path
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (req_i.addr)
      nic_misc_csr_pkg::OFS_IER: begin
        rd_val[nic_misc_csr_pkg::IER_NORMAL] = normal_summary_en_q;
        rd_val[nic_misc_csr_pkg::IER_ABNORMAL] = abnormal_summary_en_q;
        rd_val[nic_misc_csr_pkg::IER_TIMER] = timer_expired_irq_en_q;
        rd_val[nic_misc_csr_pkg::IER_TX_DESC] = tx_desc_unavail_irq_en_q;
        rd_val[nic_misc_csr_pkg::IER_TX_STOP] = tx_stopped_irq_en_q;
        rd_val[nic_misc_csr_pkg::IER_TX_DONE] = tx_done_irq_en_q;
      end
      nic_misc_csr_pkg::OFS_LPC: begin
        rd_val[CNT_W-1:0] = dropped_frame_count_q;
        rd_val[nic_misc_csr_pkg::LPC_OVF] = dropped_count_overflow_q;
      end
      nic_misc_csr_pkg::OFS_SPR: begin
        rd_val[nic_misc_csr_pkg::SPR_RD] = eeprom_read_ctrl_q;
        rd_val[nic_misc_csr_pkg::SPR_WR] = eeprom_write_ctrl_q;
        rd_val[nic_misc_csr_pkg::SPR_SEL] = eeprom_port_select_q;
        rd_val[nic_misc_csr_pkg::SPR_DO] = eeprom_serial_out_q;
        rd_val[nic_misc_csr_pkg::SPR_DI] = eeprom_serial_in_q;
        rd_val[nic_misc_csr_pkg::SPR_CLK] = eeprom_clk_q;
        rd_val[nic_misc_csr_pkg::SPR_CS] = eeprom_chip_sel_q;
      end
      nic_misc_csr_pkg::OFS_TMR: begin
        rd_val[15:0] = timer_count_q;
        rd_val[nic_misc_csr_pkg::TMR_CONT] = timer_continuous_q;
      end
      nic_misc_csr_pkg::OFS_IRQ_STAT: begin
        rd_val[nic_misc_csr_pkg::N_EVT-1:0] = irq_status_q;
      end
      nic_misc_csr_pkg::OFS_IRQ_MASK: begin
        rd_val[nic_misc_csr_pkg::N_EVT-1:0] = irq_mask_q;
      end
      default: begin
        rd_val = 32'h0000_0000; // unmapped and wake-up word read zero
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_o <= req_i.rd ? rd_val : 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  chk_irq_tx_done: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && irq_status_q[nic_misc_csr_pkg::ST_TX_DONE] &&
     irq_mask_q[nic_misc_csr_pkg::ST_TX_DONE] && tx_done_irq_en_q &&
     normal_summary_en_q) |=> irq_o)
    else $error("tx done interrupt not raised");
  chk_irq_tx_desc: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && irq_status_q[nic_misc_csr_pkg::ST_TX_DESC] &&
     irq_mask_q[nic_misc_csr_pkg::ST_TX_DESC] &&
     tx_desc_unavail_irq_en_q && normal_summary_en_q) |=> irq_o)
    else $error("descriptor unavailable interrupt not raised");
  chk_irq_tx_stop: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && irq_status_q[nic_misc_csr_pkg::ST_TX_STOP] &&
     irq_mask_q[nic_misc_csr_pkg::ST_TX_STOP] && tx_stopped_irq_en_q &&
     abnormal_summary_en_q) |=> irq_o)
    else $error("tx stopped interrupt not raised");
  chk_sum_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && !normal_summary_en_q && !abnormal_summary_en_q &&
     !(irq_status_q[nic_misc_csr_pkg::ST_LPC_OVF] &&
       irq_mask_q[nic_misc_csr_pkg::ST_LPC_OVF])) |=> !irq_o)
    else $error("interrupt raised with both summaries off");
  chk_lpc_incr: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && frame_dropped_i && !rd_lpc && !(&dropped_frame_count_q))
    |=> dropped_frame_count_q == $past(dropped_frame_count_q) + CNT_ONE)
    else $error("lost count did not step by one");
  chk_lpc_clear: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && rd_lpc && !frame_dropped_i) |=>
    (dropped_frame_count_q == '0) && !dropped_count_overflow_q)
    else $error("lost counter not cleared by read");
  chk_lpc_ovf_set: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && frame_dropped_i && !rd_lpc && (&dropped_frame_count_q))
    |=> dropped_count_overflow_q && (&dropped_frame_count_q))
    else $error("overflow flag not set at top of count");
  chk_lpc_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    (dropped_count_overflow_q && !(ce_i && rd_lpc)) |=>
    (&dropped_frame_count_q) && dropped_count_overflow_q)
    else $error("lost count left maximum while overflowed");
  chk_ee_grant: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && !eeprom_port_select_q) |=> !eeprom_o.cs && !eeprom_o.clk)
    else $error("eeprom pins active without select");
  chk_ee_dout: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && ee_rd_grant) |=>
    eeprom_serial_out_q == $past(eeprom_serial_out_i))
    else $error("eeprom data-out not captured");
  chk_tmr_step: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && !wr_tmr && tmr_state_q == nic_misc_csr_pkg::TMR_RUN &&
     tick_end && timer_count_q > 16'h0001) |=>
    timer_count_q == $past(timer_count_q) - 16'h0001)
    else $error("timer did not step down on tick");
  chk_tmr_stop: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && timer_evt && !timer_continuous_q) |=>
    tmr_state_q == nic_misc_csr_pkg::TMR_IDLE &&
    timer_count_q == 16'h0000 &&
    irq_status_q[nic_misc_csr_pkg::ST_TIMER])
    else $error("one-shot timer did not stop at zero");
  chk_tmr_reload: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && timer_evt && timer_continuous_q) |=>
    timer_count_q == $past(timer_load_value_q) &&
    tmr_state_q == nic_misc_csr_pkg::TMR_RUN)
    else $error("continuous timer did not reload");

endmodule

// ---- core/nic_misc_csr_pkg.sv ----
// constants and types shared by the misc csr bank
package nic_misc_csr_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_IER = 8'h38;
  localparam logic [7:0] OFS_LPC = 8'h40;
  localparam logic [7:0] OFS_SPR = 8'h48;
  localparam logic [7:0] OFS_TMR = 8'h58;
  localparam logic [7:0] OFS_WAKEUP_CONTROL_STATUS = 8'h68;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h78;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h7c;

  // ==========================================================
  // interrupt enable field positions
  localparam int IER_TX_DONE = 0;
  localparam int IER_TX_STOP = 1;
  localparam int IER_TX_DESC = 2;
  localparam int IER_TIMER = 11;
  localparam int IER_ABNORMAL = 15;
  localparam int IER_NORMAL = 16;

  // ==========================================================
  // lost counter, serial port and timer field positions
  localparam int LPC_OVF = 16;
  localparam int SPR_CS = 0;
  localparam int SPR_CLK = 1;
  localparam int SPR_DI = 2;
  localparam int SPR_DO = 3;
  localparam int SPR_SEL = 11;
  localparam int SPR_WR = 13;
  localparam int SPR_RD = 14;
  localparam int TMR_CONT = 16;

  // ==========================================================
  // values after reset
  localparam logic SPR_PIN_RST = 1'b1;
  localparam logic [15:0] TMR_VALUE_RST = 16'h0000;

  // ==========================================================
  // event status bit positions
  localparam int ST_TX_DONE = 0;
  localparam int ST_TX_STOP = 1;
  localparam int ST_TX_DESC = 2;
  localparam int ST_TIMER = 3;
  localparam int ST_LPC_OVF = 4;
  localparam int N_EVT = 5;

  // ==========================================================
  // timer tick: time in its own unit, cycles derived from clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_US = 204;
  localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } csr_req_t;

  typedef struct packed {
    logic cs;
    logic clk;
    logic di;
  } ee_pins_t;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b01,
    TMR_RUN = 2'b10
  } tmr_state_t;

endpackage

// ---- dv/eeprom_model.sv ----
// behavioural serial eeprom seen from the csr bank's serial port
`timescale 1ns/10ps
module eeprom_model (
  // pins from the device
  input wire nic_misc_csr_pkg::ee_pins_t pins_i,
  // data back to the device
  output logic dout_o
);
  // ==========================================
  // shift register with a known start pattern
  logic [15:0] sr_q = 16'ha5c3;

  // shift in data-in on each rising serial clock while chip selected
  always @(posedge pins_i.clk) begin
    if (pins_i.cs) begin
      sr_q <= {sr_q[14:0], pins_i.di};
    end
  end

  // deselected output is not held: show the inverse so no stale match
  assign dout_o = pins_i.cs ? sr_q[15] : ~sr_q[15];
endmodule

// ---- dv/nic_misc_csr_bank_tb.sv ----
// self-checking bench for the misc csr bank
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module nic_misc_csr_bank_tb;
  // ==========================================
  // signals
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  nic_misc_csr_pkg::csr_req_t req_i = '0;
  logic [31:0] rdata_o;
  logic drop = 1'b0;
  logic [2:0] ev = 3'b000;
  logic so;
  nic_misc_csr_pkg::ee_pins_t eeprom_o;
  logic irq_o;
  logic [31:0] d;
  int fails = 0;
  int total_checks = 0;

  // short tick keeps timer scenarios to a few dozen cycles
  nic_misc_csr_bank #(.CNT_W(16), .TICK_CYCLES(8)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .req_i(req_i),
    .rdata_o(rdata_o), .frame_dropped_i(drop), .tx_done_i(ev[0]),
    .tx_stopped_i(ev[1]), .tx_desc_unavail_i(ev[2]),
    .eeprom_serial_out_i(so), .eeprom_o(eeprom_o), .irq_o(irq_o)
  );
  eeprom_model i_mdl (.pins_i(eeprom_o), .dout_o(so));

  always #25 clk_i = ~clk_i;

  // ==========================================
  // bus and stimulus helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    req_i.addr <= a;
    req_i.wdata <= v;
    req_i.wr <= 1'b1;
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    req_i.addr <= a;
    req_i.rd <= 1'b1;
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic drops(input int n);
    @(posedge clk_i);
    drop <= 1'b1;
    repeat (n) @(posedge clk_i);
    drop <= 1'b0;
  endtask
  task automatic pulse_ev(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_irq(input int max);
    int n;
    n = 0;
    while (irq_o !== 1'b1) begin
      if (n > max) begin
        fails++;
        print_verdict();
      end
      n++;
      cyc(1);
    end
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    rd(nic_misc_csr_pkg::OFS_SPR, d);
    `CHK(d, 32'h0000000f)
    rd(nic_misc_csr_pkg::OFS_LPC, d);
    `CHK(d, 32'h00000000)
    rd(nic_misc_csr_pkg::OFS_TMR, d);
    `CHK(d, 32'h00000000)
    rd(nic_misc_csr_pkg::OFS_IER, d);
    `CHK(d, 32'h00000000)
    rd(8'h20, d);
    `CHK(d, 32'h00000000)
    `CHK(eeprom_o, 3'b000)
    $display("end reset");
  endtask
  task automatic t_lost();
    drops(3);
    rd(nic_misc_csr_pkg::OFS_LPC, d);
    `CHK(d, 32'h00000003)
    rd(nic_misc_csr_pkg::OFS_LPC, d);
    `CHK(d, 32'h00000000)
    // clock enable low freezes the count: these drops are not seen
    @(posedge clk_i);
    ce_i <= 1'b0;
    drops(3);
    ce_i <= 1'b1;
    rd(nic_misc_csr_pkg::OFS_LPC, d);
    `CHK(d, 32'h00000000)
    // one past the top of the count: flag up, count pinned
    drops(65536);
    rd(nic_misc_csr_pkg::OFS_LPC, d);
    `CHK(d, 32'h0001ffff)
    rd(nic_misc_csr_pkg::OFS_IRQ_STAT, d);
    `CHK(d, 32'h00000010)
    rd(nic_misc_csr_pkg::OFS_LPC, d);
    `CHK(d, 32'h00000000)
    wr(nic_misc_csr_pkg::OFS_IRQ_STAT, 32'h00000010);
    $display("end lost");
  endtask
  task automatic t_eeprom();
    wr(nic_misc_csr_pkg::OFS_SPR, 32'h00004801);
    cyc(3);
    rd(nic_misc_csr_pkg::OFS_SPR, d);
    `CHK(d, 32'h00004809)
    `CHK(eeprom_o, 3'b100)
    // rising clock shifts a zero in: next data-out bit is 0
    wr(nic_misc_csr_pkg::OFS_SPR, 32'h00004803);
    cyc(3);
    rd(nic_misc_csr_pkg::OFS_SPR, d);
    `CHK(d, 32'h00004803)
    `CHK(eeprom_o, 3'b110)
    wr(nic_misc_csr_pkg::OFS_SPR, 32'h00000807);
    cyc(3);
    `CHK(eeprom_o, 3'b000)
    wr(nic_misc_csr_pkg::OFS_SPR, 32'h00002005);
    cyc(3);
    `CHK(eeprom_o, 3'b000)
    // no read grant: data-out bit keeps the last granted sample
    rd(nic_misc_csr_pkg::OFS_SPR, d);
    `CHK(d, 32'h00002005)
    wr(nic_misc_csr_pkg::OFS_SPR, 32'h00002805);
    cyc(3);
    `CHK(eeprom_o, 3'b101)
    $display("end eeprom");
  endtask
  task automatic t_irq();
    int summ[3] = '{16, 15, 16};
    logic [31:0] b;
    wr(nic_misc_csr_pkg::OFS_IRQ_MASK, 32'h0000001f);
    for (int i = 0; i < 3; i++) begin
      b = 32'h1 << i;
      pulse_ev(i);
      // enable bit with the wrong summary must stay quiet
      wr(nic_misc_csr_pkg::OFS_IER, b | (32'h1 << (31 - summ[i])));
      cyc(3);
      `CHK(irq_o, 1'b0)
      wr(nic_misc_csr_pkg::OFS_IER, b | (32'h1 << summ[i]));
      cyc(3);
      `CHK(irq_o, 1'b1)
      wr(nic_misc_csr_pkg::OFS_IRQ_MASK, 32'h00000000);
      cyc(3);
      `CHK(irq_o, 1'b0)
      wr(nic_misc_csr_pkg::OFS_IRQ_MASK, 32'h0000001f);
      wr(nic_misc_csr_pkg::OFS_IER, 32'h1 << summ[i]);
      cyc(3);
      `CHK(irq_o, 1'b0)
      rd(nic_misc_csr_pkg::OFS_IRQ_STAT, d);
      `CHK(d, b)
      wr(nic_misc_csr_pkg::OFS_IRQ_STAT, b);
      rd(nic_misc_csr_pkg::OFS_IRQ_STAT, d);
      `CHK(d, 32'h00000000)
    end
    $display("end irq");
  endtask
  task automatic t_timer();
    wr(nic_misc_csr_pkg::OFS_IER, 32'h00008800);
    wr(nic_misc_csr_pkg::OFS_TMR, 32'h00000002);
    cyc(10);
    `CHK(irq_o, 1'b0)
    wait_irq(40);
    rd(nic_misc_csr_pkg::OFS_TMR, d);
    `CHK(d, 32'h00000000)
    wr(nic_misc_csr_pkg::OFS_IRQ_STAT, 32'h00000008);
    cyc(40);
    `CHK(irq_o, 1'b0)
    wr(nic_misc_csr_pkg::OFS_TMR, 32'h00010002);
    wait_irq(40);
    rd(nic_misc_csr_pkg::OFS_TMR, d);
    `CHK(d, 32'h00010002)
    wr(nic_misc_csr_pkg::OFS_IRQ_STAT, 32'h00000008);
    cyc(3);
    `CHK(irq_o, 1'b0)
    wait_irq(40);
    wr(nic_misc_csr_pkg::OFS_TMR, 32'h00000000);
    $display("end timer");
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_lost();
    t_eeprom();
    t_irq();
    t_timer();
    print_verdict();
  end
endmodule
